// File: common/mcu_pwr_defines.vh
// constants for the reset, clock divider and power mode controller
`ifndef MCU_PWR_DEFINES_VH
`define MCU_PWR_DEFINES_VH
// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFS_POWER_CONTROL  4'h0
`define OFS_STATUS         4'h4
`define OFS_SECURITY       4'h8
// ----------------------------------------------------------------------------
// power control fields
// ----------------------------------------------------------------------------
`define PWR_IDLE_BIT       0
`define PWR_PDOWN_BIT      1
`define PWR_FLAG0_BIT      2
`define PWR_FLAG1_BIT      3
`define PWR_RESET          4'h0
`define SECURITY_RESET     2'h0
// ----------------------------------------------------------------------------
// modes
// ----------------------------------------------------------------------------
`define MODE_RUN           2'h0
`define MODE_IDLE          2'h1
`define MODE_PDOWN         2'h2
// ----------------------------------------------------------------------------
// timing, rom map, bus answers
// ----------------------------------------------------------------------------
`define OSC_PER_MCYCLE     12
`define RST_MCYCLES        2
`define RST_OSC_PERIODS    5'h18
`define ROM_USER_LAST      16'h0fff
`define ROM_KEY_FIRST      16'h1000
`define ROM_KEY_LAST       16'h101f
`define ROM_GUARD_ADDR     16'h1020
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

// File: verilog/osc_div2.v
// oscillator edge detector and divide-by-two flip-flop
`timescale 1ns/1ps
module osc_div2 (
  input  wire aclk,
  input  wire aresetn,
  input  wire ce,
  input  wire osc_input,
  input  wire osc_enable,
  output reg  osc_rise,
  output reg  clk_div2_r
);
  reg osc_prev_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_prev_r <= 1'b0;
      osc_rise   <= 1'b0;
      clk_div2_r <= 1'b0;
    end else if (ce) begin
      osc_prev_r <= osc_input;
      osc_rise   <= osc_enable & osc_input & ~osc_prev_r;
      // only rising edges toggle, so input duty cycle is irrelevant
      if (osc_enable && osc_input && !osc_prev_r) begin
        clk_div2_r <= ~clk_div2_r;
      end
    end
  end
endmodule // osc_div2

// File: verilog/rst_filter.v
// reset pin qualifier counting oscillator periods
`timescale 1ns/1ps
`include "mcu_pwr_defines.vh"
module rst_filter (
  input  wire aclk,
  input  wire aresetn,
  input  wire ce,
  input  wire osc_rise,
  input  wire reset_pin,
  output reg  core_reset_r,
  output reg  release_r
);
  reg [4:0] cnt_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r        <= 5'h00;
      core_reset_r <= 1'b1;
      release_r    <= 1'b0;
    end else if (ce) begin
      release_r <= core_reset_r & ~reset_pin;
      if (!reset_pin) begin
        cnt_r        <= 5'h00;
        core_reset_r <= 1'b0;
      end else if (osc_rise) begin
        // counts only while the oscillator delivers edges
        if (cnt_r == `RST_OSC_PERIODS - 5'h01) begin
          core_reset_r <= 1'b1;
        end
        if (cnt_r != `RST_OSC_PERIODS) begin
          cnt_r <= cnt_r + 5'h01;
        end
      end
    end
  end
endmodule // rst_filter

// File: verilog/mcu_reset_power_mode_ctrl.v
// reset, clock division, idle / power-down and rom security control
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "mcu_pwr_defines.vh"
// Overview of operation
// - reset pin high for 24 running oscillator periods causes a reset.
// - oscillator input feeds a divide-by-two flip-flop before internal clocking.
// - idle halts the core, peripherals keep running; request is last instruction.
// - idle preserves core state, ram and special function registers.
// - any enabled interrupt ends idle and resumes at its service routine.
// - hardware reset ends idle and restarts like a power-on reset.
// - power-down stops the oscillator; request is the last instruction.
// - power-down keeps only the on-chip ram contents.
// - only a hardware reset ends power-down; interrupts do not wake.
// - both mode request bits live in the power control register.
// - idle drives both strobes high; external memory floats port 0, port 2 addresses.
// - power-down drives both strobes low; external memory floats port 0.
// - security bit 1 blocks code table reads aimed at external memory.
// - security bit 1 latches external access select at reset.
// - security bit 2 refuses verify reads of user rom.
// - rom image: code 0000-0fff, key 1000-101f, security bits at 1020.
module mcu_reset_power_mode_ctrl (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        reset_pin,
  input  wire        osc_input,
  output reg         osc_output,
  output reg         osc_enable_r,
  output wire        clk_div2,
  output wire        core_reset,
  output reg         core_halt_r,
  output reg         periph_run_r,
  output reg         ram_retain_r,
  input  wire        irq_pending,
  input  wire        external_access_select,
  input  wire        core_ale,
  input  wire        core_program_store_strobe,
  input  wire        core_p0_oe_n,
  output reg         ale_r,
  output reg         program_store_strobe,
  output reg         p0_oe_n_r,
  output reg         p2_addr_sel_r,
  input  wire        code_rd_req,
  input  wire [15:0] code_rd_addr,
  output reg         code_rd_allow_r,
  input  wire        verify_req,
  input  wire [15:0] verify_addr,
  output reg         verify_allow_r
);
  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  localparam [1:0] ST_RUN   = `MODE_RUN;
  localparam [1:0] ST_IDLE  = `MODE_IDLE;
  localparam [1:0] ST_PDOWN = `MODE_PDOWN;

  reg  [1:0]  mode_r;
  reg  [1:0]  mode_nxt;
  reg  [3:0]  power_control_reg;
  reg  [1:0]  rom_security_bits;
  reg         ext_sel_held_r;
  reg  [3:0]  awaddr_r;
  reg         aw_have_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  reg         w_have_r;
  wire        osc_rise;
  wire        rst_release;
  wire        ext_sel_eff;
  wire        ext_mem;
  wire        wr_go;
  wire        wr_power;
  wire        wr_security;
  wire        idle_exit;
  wire        code_ext;
  wire        verify_ok;
  reg  [31:0] rd_val;
  reg         rd_hit;

  // --------------------------------------------------------------------------
  // clock divider and reset qualifier
  // --------------------------------------------------------------------------
  osc_div2 u_div (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ce         (ce),
    .osc_input  (osc_input),
    .osc_enable (osc_enable_r),
    .osc_rise   (osc_rise),
    .clk_div2_r (clk_div2)
  );

  rst_filter u_rst (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .ce           (ce),
    .osc_rise     (osc_rise),
    .reset_pin    (reset_pin),
    .core_reset_r (core_reset),
    .release_r    (rst_release)
  );

  // --------------------------------------------------------------------------
  // security and external access
  // --------------------------------------------------------------------------
  // latched copy stands only once bit 1 is programmed
  assign ext_sel_eff = rom_security_bits[0] ? ext_sel_held_r : external_access_select;
  assign ext_mem  = ~ext_sel_eff;
  assign code_ext = ext_mem | (code_rd_addr > `ROM_USER_LAST);
  assign verify_ok = ~rom_security_bits[1] & (verify_addr <= `ROM_USER_LAST);

  always @(posedge aclk) begin
    if (!aresetn) begin
      ext_sel_held_r  <= 1'b1;
      code_rd_allow_r <= 1'b0;
      verify_allow_r  <= 1'b0;
    end else if (ce) begin
      if (rst_release) begin
        ext_sel_held_r <= external_access_select;
      end
      code_rd_allow_r <= code_rd_req & ~(rom_security_bits[0] & code_ext);
      verify_allow_r  <= verify_req & verify_ok;
    end
  end

  // --------------------------------------------------------------------------
  // register bus write path
  // --------------------------------------------------------------------------
  assign wr_go   = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign wr_power    = wr_go & (awaddr_r == `OFS_POWER_CONTROL) & wstrb_r[0];
  assign wr_security = wr_go & (awaddr_r == `OFS_SECURITY) & wstrb_r[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      awaddr_r      <= 4'h0;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r      <= s_axi_awaddr;
        aw_have_r     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        w_have_r     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        if (awaddr_r == `OFS_POWER_CONTROL || awaddr_r == `OFS_SECURITY) begin
          s_axi_bresp <= `RESP_OKAY;
        end else if (awaddr_r == `OFS_STATUS) begin
          s_axi_bresp <= `RESP_OKAY;
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_have_r     <= 1'b0;
        w_have_r      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // power control and security registers
  // --------------------------------------------------------------------------
  assign idle_exit = (mode_r == ST_IDLE) & irq_pending;

  always @(posedge aclk) begin
    if (!aresetn) begin
      power_control_reg <= `PWR_RESET;
      rom_security_bits <= `SECURITY_RESET;
    end else if (ce) begin
      if (core_reset) begin
        power_control_reg <= `PWR_RESET;
      end else if (wr_power) begin
        power_control_reg <= wdata_r[3:0];
      end else if (idle_exit) begin
        power_control_reg[`PWR_IDLE_BIT] <= 1'b0;
      end
      // programmed bits cannot be erased
      if (wr_security) begin
        rom_security_bits <= rom_security_bits | wdata_r[1:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // register bus read path
  // --------------------------------------------------------------------------
  always @* begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `OFS_POWER_CONTROL: rd_val = {28'h000_0000, power_control_reg};
      `OFS_STATUS:        rd_val = {26'h000_0000, ext_mem, ext_sel_held_r,
                                    core_reset, clk_div2, mode_r};
      `OFS_SECURITY:      rd_val = {30'h0000_0000, rom_security_bits};
      default:            rd_hit = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // mode state machine
  // --------------------------------------------------------------------------
  always @* begin
    mode_nxt = mode_r;
    case (mode_r)
      ST_RUN: begin
        if (power_control_reg[`PWR_PDOWN_BIT]) begin
          mode_nxt = ST_PDOWN;
        end else if (power_control_reg[`PWR_IDLE_BIT]) begin
          mode_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (irq_pending) begin
          mode_nxt = ST_RUN;
        end
      end
      ST_PDOWN: begin
        mode_nxt = ST_PDOWN;
      end
      default: begin
        mode_nxt = ST_RUN;
      end
    endcase
    if (core_reset) begin
      mode_nxt = ST_RUN;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= ST_RUN;
    end else if (ce) begin
      mode_r <= mode_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // mode outputs and pin states
  // --------------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_enable_r         <= 1'b1;
      osc_output           <= 1'b0;
      core_halt_r          <= 1'b0;
      periph_run_r         <= 1'b1;
      ram_retain_r         <= 1'b0;
      ale_r                <= 1'b1;
      program_store_strobe <= 1'b1;
      p0_oe_n_r            <= 1'b1;
      p2_addr_sel_r        <= 1'b0;
    end else if (ce) begin
      // reset pin restarts the stopped oscillator so the qualifier can count
      osc_enable_r <= (mode_nxt != ST_PDOWN) | reset_pin;
      osc_output   <= osc_enable_r & ~osc_input;
      case (mode_nxt)
        ST_IDLE: begin
          core_halt_r          <= 1'b1;
          periph_run_r         <= 1'b1;
          ram_retain_r         <= 1'b0;
          ale_r                <= 1'b1;
          program_store_strobe <= 1'b1;
          p0_oe_n_r            <= ext_mem ? 1'b1 : core_p0_oe_n;
          p2_addr_sel_r        <= ext_mem;
        end
        ST_PDOWN: begin
          core_halt_r          <= 1'b1;
          periph_run_r         <= 1'b0;
          ram_retain_r         <= 1'b1;
          ale_r                <= 1'b0;
          program_store_strobe <= 1'b0;
          p0_oe_n_r            <= ext_mem ? 1'b1 : core_p0_oe_n;
          p2_addr_sel_r        <= 1'b0;
        end
        default: begin
          core_halt_r          <= 1'b0;
          periph_run_r         <= 1'b1;
          ram_retain_r         <= 1'b0;
          ale_r                <= core_ale;
          program_store_strobe <= core_program_store_strobe;
          p0_oe_n_r            <= core_p0_oe_n;
          p2_addr_sel_r        <= ext_mem;
        end
      endcase
    end
  end
endmodule // mcu_reset_power_mode_ctrl

// File: verif/mcu_pwr_props.sv
// assertions for the reset and power mode controller
`timescale 1ns/1ps
module mcu_pwr_props (
  input wire        aclk,
  input wire        aresetn,
  input wire        reset_pin,
  input wire        osc_input,
  input wire        osc_enable_r,
  input wire        clk_div2,
  input wire        core_reset,
  input wire        core_halt_r,
  input wire        periph_run_r,
  input wire        ram_retain_r,
  input wire        irq_pending,
  input wire        ale_r,
  input wire        program_store_strobe,
  input wire        code_rd_req,
  input wire        code_rd_allow_r,
  input wire        verify_req,
  input wire [15:0] verify_addr,
  input wire        verify_allow_r
);
  reg  [7:0] hi_r;
  wire       idle = core_halt_r & periph_run_r;
  wire       pdn  = core_halt_r & ~periph_run_r;
  // ----------------------------------------------------------------
  // cycles the reset pin has stayed high
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn || !reset_pin)
      hi_r <= 8'h00;
    else if (hi_r != 8'hff)
      hi_r <= hi_r + 8'h01;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_rst_len; $rose(core_reset) |-> hi_r >= 8'h6e; endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset too early");
  property p_div;
    $rose(osc_input) && osc_enable_r ##1 osc_enable_r |-> ##[0:2] $changed(clk_div2);
  endproperty
  a_div: assert property (p_div) else $error("divider missed edge");
  property p_idle_pins; idle && $past(idle) |-> ale_r && program_store_strobe; endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("idle strobes");
  property p_pdn_pins; pdn && $past(pdn) |-> !ale_r && !program_store_strobe; endproperty
  a_pdn_pins: assert property (p_pdn_pins) else $error("power-down strobes");
  property p_pdn_osc; pdn && $past(pdn) && !$past(reset_pin) |-> !osc_enable_r; endproperty
  a_pdn_osc: assert property (p_pdn_osc) else $error("oscillator runs");
  property p_pdn_hold; ram_retain_r && !core_reset |=> ram_retain_r || core_reset; endproperty
  a_pdn_hold: assert property (p_pdn_hold) else $error("power-down left");
  property p_wake; idle && irq_pending |-> ##[1:3] !core_halt_r; endproperty
  a_wake: assert property (p_wake) else $error("idle not ended");
  property p_rst_run; core_reset [*4] |-> !core_halt_r && !ram_retain_r; endproperty
  a_rst_run: assert property (p_rst_run) else $error("reset not running");
  property p_code; !code_rd_req |=> !code_rd_allow_r; endproperty
  a_code: assert property (p_code) else $error("code read allowed");
  property p_verify; verify_req && verify_addr > 16'h0fff |=> !verify_allow_r; endproperty
  a_verify: assert property (p_verify) else $error("verify allowed");
  c_idle: cover property ($rose(idle));
  c_pdn: cover property ($rose(pdn));
  c_rst: cover property ($rose(core_reset));
endmodule // mcu_pwr_props
bind mcu_reset_power_mode_ctrl mcu_pwr_props u_props (.*);

// File: verif/reset_src_model.sv
// external reset source and oscillator model
`timescale 1ns/1ps
module reset_src_model (
  input  wire aclk,
  input  wire osc_enable_r,
  output reg  reset_pin,
  output reg  osc_input
);
  reg [2:0] cnt_r;
  initial begin
    reset_pin = 1'b1;
    osc_input = 1'b0;
    cnt_r = 3'h0;
  end
  // uneven duty, still while the device stops it
  always @(posedge aclk) begin
    if (osc_enable_r !== 1'b1) begin
      cnt_r <= 3'h0;
      osc_input <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == 3'h4) ? 3'h0 : cnt_r + 3'h1;
      osc_input <= (cnt_r == 3'h4);
    end
  end
  task hold(input integer periods);
    begin
      @(posedge aclk);
      reset_pin <= 1'b1;
      repeat (periods * 5) @(posedge aclk);
    end
  endtask
  task drop;
    begin
      reset_pin <= 1'b0;
    end
  endtask
endmodule // reset_src_model

// File: verif/tb.sv
// self-checking bench for the reset and power mode controller
`timescale 1ns/1ps
`include "mcu_pwr_defines.vh"
module tb;
  reg         aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  reg  [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg         irq_pending = 1'b0, external_access_select = 1'b1;
  reg         core_ale = 1'b0, core_program_store_strobe = 1'b0, core_p0_oe_n = 1'b0;
  reg         code_rd_req = 1'b0, verify_req = 1'b0;
  reg  [15:0] code_rd_addr = 16'h0, verify_addr = 16'h0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        reset_pin, osc_input, osc_output, osc_enable_r, clk_div2, core_reset;
  wire        core_halt_r, periph_run_r, ram_retain_r, ale_r, program_store_strobe;
  wire        p0_oe_n_r, p2_addr_sel_r, code_rd_allow_r, verify_allow_r;
  integer     failures = 0, check_count = 0;
  always #10 aclk = ~aclk;
  mcu_reset_power_mode_ctrl u_mcu_reset_power_mode_ctrl (.*);
  reset_src_model u_src (.aclk(aclk), .osc_enable_r(osc_enable_r), .reset_pin(reset_pin),
    .osc_input(osc_input));
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task conclude;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task check(input [95:0] name, input [31:0] exp, input [31:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("mismatch %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task stuck;
    begin
      failures = failures + 1;
      $display("mismatch handshake expected 1 seen 0");
      conclude;
    end
  endtask
  task axi_wr(input [3:0] a, input [31:0] d, input [1:0] er);
    integer n;
    reg     done;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      done = 1'b0;
      for (n = 0; n < 64 && !done; n = n + 1) begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) begin
          done = 1'b1;
          s_axi_bready <= 1'b0;
          check("bresp", er, s_axi_bresp);
        end
      end
      if (!done) stuck;
    end
  endtask
  task axi_rd(input [3:0] a, input [31:0] m, input [31:0] e, input [1:0] er);
    integer n;
    reg     done;
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      done = 1'b0;
      for (n = 0; n < 64 && !done; n = n + 1) begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) begin
          done = 1'b1;
          s_axi_rready <= 1'b0;
          check("rresp", er, s_axi_rresp);
          check("rdata", e, s_axi_rdata & m);
        end
      end
      if (!done) stuck;
    end
  endtask
  task settle;
    begin
      repeat (4) @(posedge aclk);
      #1;
    end
  endtask
  task pin_reset;
    begin
      u_src.hold(30);
      #1 check("core_reset", 32'h1, core_reset);
      u_src.drop;
      settle;
      check("core_reset", 32'h0, core_reset);
    end
  endtask
  task probe(input v, input [15:0] a, input e);
    begin
      @(posedge aclk);
      code_rd_req <= !v;
      code_rd_addr <= a;
      verify_req <= v;
      verify_addr <= a;
      @(posedge aclk);
      #1 check("allow", e, v ? verify_allow_r : code_rd_allow_r);
      code_rd_req <= 1'b0;
      verify_req <= 1'b0;
    end
  endtask
  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`OFS_POWER_CONTROL, 32'hf, 32'h0, `RESP_OKAY);
    axi_rd(`OFS_SECURITY, 32'h3, 32'h0, `RESP_OKAY);
    axi_rd(`OFS_STATUS, 32'h8, 32'h8, `RESP_OKAY);
    pin_reset;
    u_src.hold(20);
    #1 check("core_reset", 32'h0, core_reset);
    u_src.drop;
    axi_wr(`OFS_POWER_CONTROL, 32'hc, `RESP_OKAY);
    pin_reset;
    axi_rd(`OFS_POWER_CONTROL, 32'hf, 32'h0, `RESP_OKAY);
    $display("test reset done");
    axi_wr(4'h1, 32'h1, `RESP_SLVERR);
    axi_rd(4'hc, 32'h0, 32'h0, `RESP_SLVERR);
    axi_wr(`OFS_STATUS, 32'h3, `RESP_OKAY);
    s_axi_wstrb <= 4'h0;
    axi_wr(`OFS_POWER_CONTROL, 32'h1, `RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    settle;
    axi_rd(`OFS_POWER_CONTROL, 32'hf, 32'h0, `RESP_OKAY);
    axi_rd(`OFS_STATUS, 32'h3, {30'h0, `MODE_RUN}, `RESP_OKAY);
    $display("test register_bus done");
    external_access_select <= 1'b0;
    axi_wr(`OFS_POWER_CONTROL, 32'h5, `RESP_OKAY);
    settle;
    check("halt", 32'h1, core_halt_r);
    check("periph", 32'h1, periph_run_r);
    check("ale", 32'h1, ale_r);
    check("pss", 32'h1, program_store_strobe);
    check("p0_float", 32'h1, p0_oe_n_r);
    check("p2_addr", 32'h1, p2_addr_sel_r);
    axi_rd(`OFS_STATUS, 32'h3, {30'h0, `MODE_IDLE}, `RESP_OKAY);
    axi_rd(`OFS_POWER_CONTROL, 32'hf, 32'h5, `RESP_OKAY);
    irq_pending <= 1'b1;
    settle;
    irq_pending <= 1'b0;
    check("halt", 32'h0, core_halt_r);
    axi_rd(`OFS_POWER_CONTROL, 32'hf, 32'h4, `RESP_OKAY);
    external_access_select <= 1'b1;
    axi_wr(`OFS_POWER_CONTROL, 32'h1, `RESP_OKAY);
    settle;
    pin_reset;
    check("halt", 32'h0, core_halt_r);
    axi_rd(`OFS_POWER_CONTROL, 32'hf, 32'h0, `RESP_OKAY);
    $display("test idle done");
    core_ale <= 1'b1;
    core_program_store_strobe <= 1'b1;
    axi_wr(`OFS_POWER_CONTROL, 32'h3, `RESP_OKAY);
    settle;
    check("osc_en", 32'h0, osc_enable_r);
    check("ale", 32'h0, ale_r);
    check("pss", 32'h0, program_store_strobe);
    check("retain", 32'h1, ram_retain_r);
    check("periph", 32'h0, periph_run_r);
    check("osc_out", 32'h0, osc_output);
    check("p0_float", 32'h0, p0_oe_n_r);
    check("p2_addr", 32'h0, p2_addr_sel_r);
    axi_rd(`OFS_STATUS, 32'h3, {30'h0, `MODE_PDOWN}, `RESP_OKAY);
    irq_pending <= 1'b1;
    settle;
    irq_pending <= 1'b0;
    check("retain", 32'h1, ram_retain_r);
    pin_reset;
    check("retain", 32'h0, ram_retain_r);
    check("osc_en", 32'h1, osc_enable_r);
    $display("test power_down done");
    axi_wr(`OFS_SECURITY, 32'h1, `RESP_OKAY);
    external_access_select <= 1'b0;
    probe(1'b0, 16'h0100, 1'b1);
    probe(1'b0, 16'h2000, 1'b0);
    probe(1'b1, 16'h0100, 1'b1);
    axi_wr(`OFS_SECURITY, 32'h2, `RESP_OKAY);
    probe(1'b1, 16'h0100, 1'b0);
    probe(1'b1, `ROM_KEY_FIRST, 1'b0);
    axi_rd(`OFS_SECURITY, 32'h3, 32'h3, `RESP_OKAY);
    axi_rd(`OFS_STATUS, 32'h10, 32'h10, `RESP_OKAY);
    $display("test security done");
    conclude;
  end
endmodule // tb
